// File: rtl/acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// Bit counts within a byte on the bus, and bus or oscillator clocks per conversion
`define ACS_TRACK_EDGE_INT   4'h8
`define ACS_ACK_EDGE         4'h9
`define ACS_HOLD_EDGE_EXT    4'h2
`define ACS_CONV_CLOCKS      4'hc
// Internal oscillator: one conversion clock per this many ref_clk cycles
`define ACS_OSC_DIV          4'h4
// Number of stored results
`define ACS_MEM_DEPTH        4'h8
// Reset configuration values
`define ACS_RST_CLK_SRC      1'h0
`define ACS_RST_INPUT_MODE   1'h1
`define ACS_RST_BIPOLAR      1'h0
`define ACS_RST_REF_SEL      3'h0
`define ACS_RST_CHAN         2'h0
`define ACS_RST_SCAN_LEN     4'h1
// Reference select role bit position and reference-out code
`define ACS_REF_ROLE_BIT     1
`define ACS_REF_OUT_CODE     2'h3
// Master side bus clock half period in ref_clk cycles and in microseconds
`define ACS_HALF_PERIOD      4'h4
`define ACS_HALF_PERIOD_US   0.4
`endif

// File: rtl/acs_pkg.sv
package acs_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ACS_IDLE,
    ACS_TRACK,
    ACS_CONV_INT,
    ACS_READ_INT,
    ACS_TRACK_EXT,
    ACS_CONV_EXT
  } acs_state_t;
endpackage

// File: rtl/acs_link_if.sv
`timescale 1ns/10ps
interface acs_link_if;
  logic        bus_clk;        // Bus clock from master
  logic        stretch;        // Device holds bus clock low
  logic        addr_match;     // Level: read-addressed frame active
  logic        nack;           // Pulse: master not-acknowledge
  logic [3:0]  bit_cnt;        // Bit number within current byte, 0..9 (0 before the first edge of a frame)
  logic        first_byte;     // Level: first result byte being sent
  logic        res_valid;      // Result word presented
  logic [11:0] res_word;       // Result word
  logic        res_take;       // Pulse: master took result
  modport device (input bus_clk, addr_match, nack, bit_cnt, first_byte, res_take,
                  output stretch, res_valid, res_word);
  modport host   (output bus_clk, addr_match, nack, bit_cnt, first_byte, res_take,
                  input stretch, res_valid, res_word);
endinterface

// File: rtl/acs_host.sv
`timescale 1ns/10ps
`include "acs_consts.svh"
module acs_host
  import acs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  acs_link_if.host         link,
  input  wire logic        start_i,      // Start a read-addressed transfer
  input  wire logic [3:0]  words_i,      // Results to read before NACK
  output logic             busy_o,
  output logic             word_valid_o,
  output logic [11:0]      word_o
);
  logic [3:0]  div_cnt;     // Half period divider
  logic [3:0]  bit_cnt;     // Bit in byte
  logic [3:0]  left;        // Words remaining
  logic        clk_q;       // Released bus clock level
  logic        byte_hi;     // Sending first byte of word
  logic        in_data;     // Address byte already sent
  logic        line_s1;     // Line synchroniser stages
  logic        line_s2;
  logic        line_d;      // Previous synchronised line level
  // High phase only counts once the line is seen high, so a held clock pauses us
  wire         line_up  = !clk_q || line_s2;
  wire         tick     = (div_cnt == `ACS_HALF_PERIOD - 4'h1) && busy_o && line_up;
  wire         l_rise   = line_s2 && !line_d && busy_o;
  wire         word_end = l_rise && (bit_cnt == `ACS_ACK_EDGE - 4'h1) && in_data && !byte_hi;

  // Open-drain clock line: the device may hold it low
  assign link.bus_clk    = clk_q && !link.stretch; // R2
  assign link.addr_match = busy_o;
  assign link.bit_cnt    = bit_cnt;
  assign link.first_byte = byte_hi;
  assign link.res_take   = word_end;
  assign link.nack       = word_end && (left == 4'h1); // R8

  // Line synchroniser, same depth as the device's
  always_ff @(posedge ref_clk_i) begin
    line_s1 <= link.bus_clk;
    line_s2 <= line_s1;
    line_d  <= line_s2;
  end

  // Bus clock generation and framing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0; bit_cnt <= 4'h0; left <= 4'h0; clk_q <= 1'h0;
      byte_hi <= 1'h0; busy_o <= 1'h0; word_valid_o <= 1'h0; word_o <= 12'h000; in_data <= 1'h0;
    end else begin
      word_valid_o <= word_end;
      if (word_end) word_o <= link.res_word;
      if (!busy_o && start_i && words_i != 4'h0) begin // R5
        busy_o <= 1'h1; left <= words_i; bit_cnt <= 4'h0; byte_hi <= 1'h0; in_data <= 1'h0; div_cnt <= 4'h0;
      end else if (busy_o) begin // R19
        div_cnt <= tick ? 4'h0 : (line_up ? div_cnt + 4'h1 : 4'h0);
        if (tick) clk_q <= !clk_q;
        if (l_rise) begin
          bit_cnt <= (bit_cnt == `ACS_ACK_EDGE) ? 4'h1 : bit_cnt + 4'h1;
          if (bit_cnt == `ACS_ACK_EDGE) begin
            byte_hi <= !byte_hi;
            in_data <= 1'h1;
          end
          if (word_end) begin
            left <= left - 4'h1;
            if (left == 4'h1) busy_o <= 1'h0;
          end
        end
      end
    end
  end
endmodule

// File: rtl/acs_device.sv
`timescale 1ns/10ps
`include "acs_consts.svh"
// Functional notes
// R1: Internal mode tracks on eighth address edge
// R2: Internal mode holds at ninth, stretches clock
// R3: Internal scan converts back to back, stores
// R4: Results read in order, pointer wraps
// R5: Fresh internal results need new read
// R6: Bus-clock mode tracks on ninth edge
// R7: Bus-clock hold at second edge, 12 clocks
// R8: Bus-clock mode converts continuously until NACK
// R9: Clock-source bit zero internal, default internal
// R10: Monitoring forces internal oscillator
// R11: Input mode selects single-ended or differential
// R12: Unipolar straight binary, negative gives zero
// R13: Bipolar gives two's complement half range
// R14: Single-ended always unipolar
// R15: Reference field; code 11 drives reference out
// R16: Reference pin acts grounded in differential
// R17: Reference pin excluded from scans
// R18: Internal reference stays on until reconfigured
// R19: Master finishes conversions within limits
// R20: Master picks mode by sample rate
// R21: Reset config single-ended unipolar first input
// R22: Completion flag and 12-bit word given
module acs_device
  import acs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  acs_link_if.device       link,
  input  wire logic        cfg_load_i,          // Load new configuration
  input  wire logic        conv_clock_source_sel_i,
  input  wire logic        input_mode_sel_i,    // 1 single-ended
  input  wire logic        bipolar_i,
  input  wire logic [2:0]  ref_sel_i,
  input  wire logic [1:0]  chan_i,
  input  wire logic [3:0]  scan_len_i,          // Conversions per scan
  input  wire logic        monitor_active_i,
  input  wire logic [11:0] adc_code_i,          // Raw comparator result, signed
  output logic             track_o,             // Track switch
  output logic             hold_o,              // Hold switch
  output logic [1:0]       mux_pos_o,
  output logic [1:0]       mux_neg_o,
  output logic             neg_is_gnd_o,
  output logic             ref_drive_o,         // Internal reference on pin
  output logic             ref_on_o,
  output logic             conv_done_o,         // Completion pulse
  output logic [11:0]      result_o
);
  logic [11:0] mem [0:7];      // Scan results
  logic        clk_src;        // Stored clock source
  logic        in_mode;        // Stored input mode
  logic        bip;            // Stored polarity
  logic [2:0]  ref_sel;        // Stored reference select
  logic [1:0]  chan;           // Stored start channel
  logic [3:0]  scan_len;       // Stored scan length
  logic [3:0]  wr_ptr;         // Write pointer
  logic [3:0]  rd_ptr;         // Read pointer
  logic [3:0]  cnt;            // Conversion clock counter
  logic [3:0]  osc_cnt;        // Oscillator divider
  logic [1:0]  cur_chan;       // Channel being converted
  logic        sclk_s1;        // Bus clock synchroniser
  logic        sclk_s2;
  logic        sclk_d;         // Previous sampled level
  logic        stretch_q;      // Clock stretch flop
  logic        valid_q;        // Result presented
  logic [11:0] word_q;         // Result to link
  acs_state_t  state;

  wire         sclk_rise  = sclk_s2 && !sclk_d;
  wire         sclk_fall  = !sclk_s2 && sclk_d;
  wire         osc_tick   = (osc_cnt == `ACS_OSC_DIV - 4'h1);
  wire         use_int    = !clk_src || monitor_active_i; // R9 R10
  wire         ref_pin    = ref_sel[`ACS_REF_ROLE_BIT];
  wire         unipolar   = in_mode || !bip; // R14
  wire [1:0]   max_chan   = ref_pin ? 2'h2 : 2'h3; // R17
  wire [3:0]   eff_len    = (ref_pin && scan_len > 4'h3) ? 4'h3 : scan_len; // R17
  wire [3:0]   scan_pos   = {2'h0, cur_chan - chan} + 4'h1; // Conversions done in this pass
  wire [1:0]   next_chan  = (cur_chan >= max_chan || scan_pos >= eff_len) ? chan : cur_chan + 2'h1;
  wire [11:0]  uni_code   = adc_code_i[11] ? 12'h000 : {adc_code_i[10:0], 1'h0}; // R12
  wire [11:0]  code       = unipolar ? uni_code : adc_code_i; // R13
  wire         conv_tick  = use_int ? osc_tick : sclk_rise;
  wire         conv_last  = conv_tick && (cnt == `ACS_CONV_CLOCKS - 4'h1);
  wire [3:0]   next_wr    = wr_ptr + 4'h1;
  wire [3:0]   next_rd    = (rd_ptr + 4'h1 >= wr_ptr) ? 4'h0 : rd_ptr + 4'h1; // R4

  assign link.stretch   = stretch_q;
  assign link.res_valid = valid_q;
  assign link.res_word  = word_q;

  // Bus clock synchroniser
  always_ff @(posedge ref_clk_i) begin
    sclk_s1 <= link.bus_clk;
    sclk_s2 <= sclk_s1;
    sclk_d  <= sclk_s2;
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin // R21
      clk_src  <= `ACS_RST_CLK_SRC;
      in_mode  <= `ACS_RST_INPUT_MODE;
      bip      <= `ACS_RST_BIPOLAR;
      ref_sel  <= `ACS_RST_REF_SEL;
      chan     <= `ACS_RST_CHAN;
      scan_len <= `ACS_RST_SCAN_LEN;
      ref_on_o <= 1'h0;
    end else begin
      if (cfg_load_i) begin
        clk_src  <= conv_clock_source_sel_i; // R9
        in_mode  <= input_mode_sel_i;
        bip      <= bipolar_i;
        ref_sel  <= ref_sel_i;
        chan     <= chan_i;
        scan_len <= (scan_len_i == 4'h0) ? 4'h1 : ((scan_len_i > `ACS_MEM_DEPTH) ? `ACS_MEM_DEPTH : scan_len_i);
        ref_on_o <= ref_sel_i[`ACS_REF_ROLE_BIT]; // R18
      end
    end
  end

  // Analog mux and reference pin
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mux_pos_o <= 2'h0; mux_neg_o <= 2'h0; neg_is_gnd_o <= 1'h1; ref_drive_o <= 1'h0;
    end else begin
      mux_pos_o    <= in_mode ? cur_chan : {cur_chan[1], 1'h0}; // R11
      mux_neg_o    <= in_mode ? 2'h0 : {cur_chan[1], 1'h1};
      neg_is_gnd_o <= in_mode || (ref_pin && cur_chan[1]); // R16
      ref_drive_o  <= (ref_sel[1:0] == `ACS_REF_OUT_CODE); // R15
    end
  end

  // Oscillator divider
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) osc_cnt <= 4'h0;
    else osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
  end

  // Sequencer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= ACS_IDLE; track_o <= 1'h0; hold_o <= 1'h0; stretch_q <= 1'h0;
      wr_ptr <= 4'h0; rd_ptr <= 4'h0; cnt <= 4'h0; cur_chan <= 2'h0;
      conv_done_o <= 1'h0; result_o <= 12'h000; valid_q <= 1'h0; word_q <= 12'h000;
    end else begin
      conv_done_o <= 1'h0;
      unique case (state)
        ACS_IDLE: begin
          track_o <= 1'h0; hold_o <= 1'h0; cur_chan <= chan; cnt <= 4'h0;
          if (link.addr_match && sclk_rise) begin
            if (use_int && link.bit_cnt == `ACS_TRACK_EDGE_INT - 4'h1) begin // R1
              track_o <= 1'h1; state <= ACS_TRACK; wr_ptr <= 4'h0;
            end else if (!use_int && link.bit_cnt == `ACS_ACK_EDGE - 4'h1) begin // R6
              track_o <= 1'h1; state <= ACS_TRACK_EXT;
            end
          end
        end
        ACS_TRACK: if (sclk_fall && link.bit_cnt == `ACS_ACK_EDGE) begin // R2
          track_o <= 1'h0; hold_o <= 1'h1; stretch_q <= 1'h1; state <= ACS_CONV_INT;
        end
        ACS_CONV_INT: if (conv_tick) begin // R3
          cnt <= conv_last ? 4'h0 : cnt + 4'h1;
          if (conv_last) begin
            mem[wr_ptr[2:0]] <= code; wr_ptr <= next_wr; cur_chan <= next_chan;
            conv_done_o <= 1'h1; result_o <= code; // R22
            if (next_wr >= eff_len) begin
              stretch_q <= 1'h0; hold_o <= 1'h0; rd_ptr <= 4'h0; state <= ACS_READ_INT;
              valid_q <= 1'h1; word_q <= mem[0];
              if (wr_ptr == 4'h0) word_q <= code;
            end
          end
        end
        ACS_READ_INT: begin // R4 R5
          if (link.res_take) begin
            rd_ptr <= next_rd; word_q <= mem[next_rd[2:0]];
          end
          if (!link.addr_match) begin
            valid_q <= 1'h0; state <= ACS_IDLE;
          end
        end
        ACS_TRACK_EXT: begin
          if (sclk_rise && link.first_byte && link.bit_cnt == `ACS_HOLD_EDGE_EXT - 4'h1) begin // R7
            track_o <= 1'h0; hold_o <= 1'h1; cnt <= 4'h0; state <= ACS_CONV_EXT;
          end
          // The NACK after the last word lands here, so leave from tracking too
          if (link.nack || !link.addr_match) begin // R8
            valid_q <= 1'h0; track_o <= 1'h0; hold_o <= 1'h0; state <= ACS_IDLE;
          end
        end
        ACS_CONV_EXT: begin // R8
          if (conv_tick) cnt <= conv_last ? 4'h0 : cnt + 4'h1;
          if (conv_last) begin
            conv_done_o <= 1'h1; result_o <= code; word_q <= code; valid_q <= 1'h1; // R22
            cur_chan <= next_chan; hold_o <= 1'h0; track_o <= 1'h1; state <= ACS_TRACK_EXT;
          end
          if (link.nack || !link.addr_match) begin
            valid_q <= 1'h0; track_o <= 1'h0; hold_o <= 1'h0; state <= ACS_IDLE;
          end
        end
        default: state <= ACS_IDLE;
      endcase
    end
  end
endmodule

// File: verification/acs_link_asserts.sv
`timescale 1ns/10ps
module acs_link_asserts (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        bus_clk,
  input  wire logic        stretch,
  input  wire logic        addr_match,
  input  wire logic        nack,
  input  wire logic [3:0]  bit_cnt,
  input  wire logic        first_byte,
  input  wire logic        res_valid,
  input  wire logic [11:0] res_word,
  input  wire logic        res_take
);
  // One domain for every check
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_stretch_low: assert property (stretch |-> !first_byte && bit_cnt == 4'h9)
    else $error("stretch outside the address acknowledge clock");
  chk_stretch_ack: assert property ($rose(stretch) |-> bit_cnt == 4'h9)
    else $error("stretch began off the ninth clock");
  chk_stretch_end: assert property (stretch |-> ##[1:900] !stretch)
    else $error("stretch never released");
  chk_stretch_frame: assert property (stretch |-> addr_match)
    else $error("stretch outside a frame");
  chk_take_valid: assert property (res_take |-> res_valid)
    else $error("result taken while not presented");
  chk_take_second: assert property (res_take |-> !first_byte)
    else $error("result taken in first byte");
  chk_bit_range: assert property (addr_match |-> bit_cnt <= 4'h9)
    else $error("bit number above nine");
  chk_clk_idle: assert property (!addr_match ##1 !addr_match |-> $stable(bus_clk))
    else $error("bus clock moved outside a frame");
  chk_clk_high: assert property ($rose(bus_clk) |-> bus_clk [*4])
    else $error("bus clock high phase too short");
  // Main scenarios reached
  cover property ($rose(stretch));
  cover property (nack);
  cover property (res_take && res_valid);
endmodule

// File: verification/adc_conversion_sequencer_tb.sv
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
  logic        ref_clk_i = 1'b0;  // 10 MHz clock
  logic        rst_i     = 1'b1;  // Synchronous reset
  logic        start_i   = 1'b0;  // Host start
  logic [3:0]  words_i   = 4'h0;  // Words per read
  logic        cfg_ld    = 1'b0;  // Configuration strobe
  logic        clk_src   = 1'b0;  // Clock source select
  logic        in_mode   = 1'b1;  // Single-ended when high
  logic        bipolar   = 1'b0;  // Bipolar select
  logic        monitor   = 1'b0;  // Monitoring active
  logic [2:0]  ref_sel   = 3'h0;  // Reference field
  logic [3:0]  scan_len  = 4'h1;  // Scan length
  logic [11:0] adc_code  = 12'h123;
  logic        busy, wvalid, track, hold, neg_gnd, ref_drv, ref_on, done, st;
  logic [1:0]  mux_p, mux_n, top;
  logic [11:0] word, res, lw;
  int          failures = 0, checks_done = 0, cycles = 0, nw, nc;
  always #50 ref_clk_i = ~ref_clk_i;
  acs_link_if acs_link_if_i ();
  acs_host acs_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(acs_link_if_i), .start_i(start_i),
    .words_i(words_i), .busy_o(busy), .word_valid_o(wvalid), .word_o(word));
  acs_device acs_device_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(acs_link_if_i), .cfg_load_i(cfg_ld),
    .conv_clock_source_sel_i(clk_src), .input_mode_sel_i(in_mode), .bipolar_i(bipolar), .ref_sel_i(ref_sel),
    .chan_i(2'h0), .scan_len_i(scan_len), .monitor_active_i(monitor),
    .adc_code_i(adc_code + {6'h00, mux_p, 4'h0}), .track_o(track),
    .hold_o(hold), .mux_pos_o(mux_p), .mux_neg_o(mux_n), .neg_is_gnd_o(neg_gnd), .ref_drive_o(ref_drv),
    .ref_on_o(ref_on), .conv_done_o(done), .result_o(res));
  acs_link_asserts acs_link_asserts_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_clk(acs_link_if_i.bus_clk),
    .stretch(acs_link_if_i.stretch), .addr_match(acs_link_if_i.addr_match), .nack(acs_link_if_i.nack),
    .bit_cnt(acs_link_if_i.bit_cnt), .first_byte(acs_link_if_i.first_byte), .res_valid(acs_link_if_i.res_valid),
    .res_word(acs_link_if_i.res_word), .res_take(acs_link_if_i.res_take));
  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Load a configuration with a one-cycle strobe
  task automatic load(input logic s, m, b, input logic [2:0] r, input logic [3:0] l, input logic [11:0] c);
    @(negedge ref_clk_i);
    {clk_src, in_mode, bipolar, ref_sel, scan_len, adc_code} = {s, m, b, r, l, c};
    cfg_ld = 1'b1;
    @(negedge ref_clk_i);
    cfg_ld = 1'b0;
  endtask
  // One host read, logging words, conversions, stretch and highest channel
  task automatic read(input logic [3:0] n);
    int t;
    {nw, nc, st, top, t} = '0;
    @(negedge ref_clk_i);
    words_i = n;
    start_i = 1'b1;
    while (t < 6000 && !(t > 3 && busy === 1'b0)) begin
      @(negedge ref_clk_i);
      t++;
      if (busy === 1'b1) start_i = 1'b0;
      if (acs_link_if_i.stretch === 1'b1) st = 1'b1;
      if (wvalid === 1'b1) begin
        nw++;
        lw = word;
      end
      if (done === 1'b1) begin
        nc++;
        if (mux_p > top) top = mux_p;
      end
    end
    if (t >= 6000) failures++;
  endtask
  task automatic s_reset();
    check({track, hold, ref_drv, ref_on, done, neg_gnd}, 12'h001);
    read(4'h1);
    check({st, nc[2:0], top}, {1'b1, 3'h1, 2'h0});
    check(lw, 12'h246);
  endtask
  task automatic s_internal();
    load(1'b0, 1'b1, 1'b0, 3'h0, 4'h3, 12'h0f0);
    read(4'h3);
    check(lw, 12'h220);
    check(nc[3:0], 4'h3);
    read(4'h4);
    check({st, nc[3:0], top}, {1'b1, 4'h3, 2'h2});
    check(nw[3:0], 4'h4);
    check(lw, 12'h1e0);
  endtask
  task automatic s_reference();
    load(1'b0, 1'b1, 1'b0, 3'h3, 4'h4, 12'h0f0);
    read(4'h4);
    check({ref_drv, 1'b0}, 2'h2);
    check(top, 2'h2);
    check(ref_on, 1'b1);
  endtask
  task automatic s_external();
    load(1'b1, 1'b1, 1'b0, 3'h0, 4'h1, 12'h0f0);
    read(4'h3);
    check({st, nw[3:0]}, {1'b0, 4'h3});
    check(lw, 12'h1e0);
    monitor = 1'b1;
    read(4'h1);
    check(st, 1'b1);
    monitor = 1'b0;
  endtask
  // Polarity table: mode, bipolar, raw code, expected word
  task automatic s_polarity();
    logic [25:0] tbl [3];
    tbl = '{{1'b0, 1'b0, 12'h900, 12'h000}, {1'b0, 1'b1, 12'hf00, 12'hf00}, {1'b1, 1'b1, 12'h0f0, 12'h1e0}};
    foreach (tbl[i]) begin
      load(1'b0, tbl[i][25], tbl[i][24], 3'h0, 4'h1, tbl[i][23:12]);
      read(4'h1);
      check(lw, tbl[i][11:0]);
      check({mux_n, neg_gnd}, tbl[i][25] ? 12'h001 : 12'h002);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_i = 1'b0;
    s_reset();
    s_internal();
    s_reference();
    s_external();
    s_polarity();
    print_verdict();
  end
endmodule
